/* src/timer_pkg.sv */
// Constants shared by the cascadable down-timer unit
package timer_pkg;
	// Register bus
	localparam int ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Byte addresses, one aligned 32-bit word each
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PORT_DIR = 8'h04;
	localparam logic [7:0] ADDR_PORT_SFR = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CNT0 = 8'h10;
	localparam logic [7:0] ADDR_LOW0 = 8'h20;
	localparam logic [7:0] ADDR_EVEN_HIGH = 8'h30;
	localparam logic [7:0] ADDR_ODD_HIGH = 8'h34;
	// Control register fields
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_AUTO_LSB = 4;
	localparam int CTRL_CASC01 = 8;
	localparam int CTRL_CASC23 = 9;
	localparam int CTRL_PWM = 10;
	localparam int CTRL_W = 11;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
	// Port bit that carries the toggle output
	localparam int TOGGLE_BIT = 1;
	// Status register fields
	localparam int STAT_TOGGLE = 0;
	localparam int STAT_PHASE_LSB = 1;
	// Timing: the crystal clock is the system clock
	localparam int CRYSTAL_CLOCK_HZ = 100_000_000;
	localparam int CRYSTAL_CLOCK_PER_TICK = 8;
	localparam logic [2:0] TICK_LAST = 3'(CRYSTAL_CLOCK_PER_TICK - 1);
	localparam logic [7:0] CNT_RESET = 8'h00;
	// Modulator phase
	typedef enum logic [1:0] {
		PWM_FIRST = 2'b00,
		PWM_LOW = 2'b01,
		PWM_HIGH = 2'b10
	} pwm_state_e;
endpackage

/* src/cascade_timers.sv */
// Four 8-bit down timers with cascading, modulator and AXI4-Lite registers
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

module cascade_timers
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic [timer_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [timer_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Per-timer interrupt requests, bit 0 is even_timer_irq
	output logic [3:0] timer_irq,
	// Toggle pin
	output logic toggle_pin_o,
	output logic toggle_pin_oe
);
	// Register state
	logic [timer_pkg::CTRL_W-1:0] ctrl;
	logic [7:0] port_b_direction;
	logic [7:0] port_b_special_function;
	logic [7:0] cnt [0:3];
	logic [7:0] low_reload [0:3];
	logic [7:0] even_high_reload;
	logic [7:0] odd_high_reload;
	logic toggle_output;
	timer_pkg::pwm_state_e pwm_state;
	logic [2:0] prescale;
	// Bus state
	logic aw_got;
	logic w_got;
	logic [timer_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	// Control fields
	wire [3:0] en = ctrl[timer_pkg::CTRL_EN_LSB +: 4];
	wire [3:0] auto_init = ctrl[timer_pkg::CTRL_AUTO_LSB +: 4];
	wire [1:0] casc = {ctrl[timer_pkg::CTRL_CASC23],
		ctrl[timer_pkg::CTRL_CASC01]};
	wire pwm_on = ctrl[timer_pkg::CTRL_PWM] & casc[0];
	wire toggle_mode = port_b_direction[timer_pkg::TOGGLE_BIT] &
		port_b_special_function[timer_pkg::TOGGLE_BIT];
	// Shared tick
	wire tick = (prescale == timer_pkg::TICK_LAST);
	// Write decode
	wire wr_fire = aw_got & w_got & ~bvalid;
	wire [7:0] wr_off = 8'(wr_addr);
	wire sel_ctrl = wr_off == timer_pkg::ADDR_CTRL;
	wire sel_dir = wr_off == timer_pkg::ADDR_PORT_DIR;
	wire sel_sfr = wr_off == timer_pkg::ADDR_PORT_SFR;
	wire sel_stat = wr_off == timer_pkg::ADDR_STATUS;
	wire sel_ehi = wr_off == timer_pkg::ADDR_EVEN_HIGH;
	wire sel_ohi = wr_off == timer_pkg::ADDR_ODD_HIGH;
	wire [3:0] sel_cnt;
	wire [3:0] sel_low;
	wire wr_hit = sel_ctrl | sel_dir | sel_sfr | sel_stat | sel_ehi |
		sel_ohi | (|sel_cnt) | (|sel_low);

	// Byte merge under a strobe
	function automatic logic [7:0] wstrb_merge8(input logic [7:0] old,
		input logic [7:0] nval, input logic strb);
		wstrb_merge8 = strb ? nval : old;
	endfunction

	// Per-timer hardware results
	wire [7:0] hw_val [0:3];
	wire [3:0] hw_we;
	wire [3:0] hw_clr_en;
	wire [3:0] irq_next;
	wire [1:0] pair_exp;
	wire [15:0] pair_reload [0:1];
	// Modulator reload choice for the expiry now under way
	wire pwm_load_high = pwm_on & (
		pwm_state == timer_pkg::PWM_LOW ? 1'b1 :
		pwm_state == timer_pkg::PWM_HIGH ? 1'b0 :
		(toggle_mode & ~toggle_output));
	assign pair_reload[0] = pwm_load_high ?
		{odd_high_reload, even_high_reload} :
		{low_reload[1], low_reload[0]};
	assign pair_reload[1] = {low_reload[3], low_reload[2]};
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_sel
			assign sel_cnt[g] = wr_off == timer_pkg::ADDR_CNT0 + 8'(4 * g);
			assign sel_low[g] = wr_off == timer_pkg::ADDR_LOW0 + 8'(4 * g);
		end
		for (g = 0; g < 2; g = g + 1)
		begin : g_pair
			localparam int E = 2 * g;
			localparam int O = 2 * g + 1;
			// Even byte is the low half of a cascaded value
			wire [15:0] v16 = {cnt[O], cnt[E]};
			wire [15:0] dec16 = v16 - 16'h0001;
			wire run_c = casc[g] & en[E] & tick;
			wire c_exp = run_c & (v16 <= 16'h0001);
			wire e_exp = ~casc[g] & en[E] & tick & (cnt[E] <= 8'h01);
			wire o_exp = ~casc[g] & en[O] & tick & (cnt[O] <= 8'h01);
			wire [15:0] c_val = c_exp ? pair_reload[g] : dec16;
			wire [7:0] e_val = auto_init[E] ? low_reload[E] : 8'h00;
			wire [7:0] o_val = auto_init[O] ? low_reload[O] : 8'h00;
			wire pwm_pair = (g == 0) & pwm_on;
			assign pair_exp[g] = c_exp | e_exp;
			assign hw_we[E] = run_c | (~casc[g] & en[E] & tick);
			assign hw_we[O] = run_c | (~casc[g] & en[O] & tick);
			assign hw_val[E] = casc[g] ? c_val[7:0] :
				(e_exp ? e_val : cnt[E] - 8'h01);
			assign hw_val[O] = casc[g] ? c_val[15:8] :
				(o_exp ? o_val : cnt[O] - 8'h01);
			assign hw_clr_en[E] = e_exp & ~auto_init[E];
			assign hw_clr_en[O] = o_exp & ~auto_init[O];
			// Cascaded pair posts on the even line, except a modulator reload of the low values, which posts on the odd line
			assign irq_next[E] = e_exp |
				(c_exp & (~pwm_pair | pwm_load_high));
			assign irq_next[O] = o_exp |
				(c_exp & pwm_pair & ~pwm_load_high);
		end
	endgenerate

	// Control word after a software write
	wire [timer_pkg::CTRL_W-1:0] ctrl_sw = {
		wr_strb[1] ? wr_data[timer_pkg::CTRL_W-1:8] :
			ctrl[timer_pkg::CTRL_W-1:8],
		wstrb_merge8(ctrl[7:0], wr_data[7:0], wr_strb[0])};
	wire [timer_pkg::CTRL_W-1:0] ctrl_base =
		(wr_fire & sel_ctrl) ? ctrl_sw : ctrl;
	wire [timer_pkg::CTRL_W-1:0] clr_mask =
		{{(timer_pkg::CTRL_W - 4){1'b0}}, hw_clr_en};

	// Prescaler
	always_ff @(posedge clk)
	begin
		if (rst)
			prescale <= 3'h0;
		else
			prescale <= prescale + 3'h1;
	end

	// Control register; the hardware clear is applied last
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= timer_pkg::CTRL_RESET;
		else
			ctrl <= ctrl_base & ~clr_mask;
	end

	// Count registers; a write starts nothing but the value
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (rst)
				cnt[i] <= timer_pkg::CNT_RESET;
			else if (wr_fire & sel_cnt[i])
				cnt[i] <= wstrb_merge8(cnt[i], wr_data[7:0], wr_strb[0]);
			else if (hw_we[i])
				cnt[i] <= hw_val[i];
		end
	end

	// Reload registers, read only at expiry
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (rst)
				low_reload[i] <= timer_pkg::CNT_RESET;
			else if (wr_fire & sel_low[i])
				low_reload[i] <= wstrb_merge8(low_reload[i], wr_data[7:0],
					wr_strb[0]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			even_high_reload <= timer_pkg::CNT_RESET;
			odd_high_reload <= timer_pkg::CNT_RESET;
		end
		else
		begin
			if (wr_fire & sel_ehi)
				even_high_reload <= wstrb_merge8(even_high_reload,
					wr_data[7:0], wr_strb[0]);
			if (wr_fire & sel_ohi)
				odd_high_reload <= wstrb_merge8(odd_high_reload,
					wr_data[7:0], wr_strb[0]);
		end
	end

	// Port configuration that gates the toggle pin
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port_b_direction <= 8'h00;
			port_b_special_function <= 8'h00;
		end
		else
		begin
			if (wr_fire & sel_dir)
				port_b_direction <= wstrb_merge8(port_b_direction,
					wr_data[7:0], wr_strb[0]);
			if (wr_fire & sel_sfr)
				port_b_special_function <= wstrb_merge8(
					port_b_special_function, wr_data[7:0], wr_strb[0]);
		end
	end

	// Modulator phase; any pause or plain mode restarts from the count
	always_ff @(posedge clk)
	begin
		if (rst)
			pwm_state <= timer_pkg::PWM_FIRST;
		else if (~pwm_on | ~en[0])
			pwm_state <= timer_pkg::PWM_FIRST;
		else if (pair_exp[0])
			pwm_state <= pwm_load_high ?
				timer_pkg::PWM_HIGH : timer_pkg::PWM_LOW;
	end

	// Toggle flip-flop clocked by timer zero end-of-count
	always_ff @(posedge clk)
	begin
		if (rst)
			toggle_output <= 1'b0;
		else if (pair_exp[0])
			toggle_output <= pwm_on ? pwm_load_high : ~toggle_output;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			toggle_pin_o <= 1'b0;
			toggle_pin_oe <= 1'b0;
			timer_irq <= 4'h0;
		end
		else
		begin
			toggle_pin_o <= (pair_exp[0] ?
				(pwm_on ? pwm_load_high : ~toggle_output) :
				toggle_output);
			toggle_pin_oe <= toggle_mode;
			timer_irq <= irq_next;
		end
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awready <= 1'b1;
			aw_got <= 1'b0;
			wr_addr <= '0;
		end
		else if (awvalid & awready)
		begin
			awready <= 1'b0;
			aw_got <= 1'b1;
			wr_addr <= awaddr;
		end
		else if (wr_fire)
			aw_got <= 1'b0;
		else if (bvalid & bready)
			awready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wready <= 1'b1;
			w_got <= 1'b0;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end
		else if (wvalid & wready)
		begin
			wready <= 1'b0;
			w_got <= 1'b1;
			wr_data <= wdata;
			wr_strb <= wstrb;
		end
		else if (wr_fire)
			w_got <= 1'b0;
		else if (bvalid & bready)
			wready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bvalid <= 1'b0;
			bresp <= timer_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// Read selection; reads never disturb the timers
	wire [7:0] rd_off = 8'(araddr);
	wire [31:0] rd_status = {29'h0, pwm_state, toggle_output};
	wire rd_cnt = rd_off[7:4] == timer_pkg::ADDR_CNT0[7:4] & ~|rd_off[1:0];
	wire rd_low = rd_off[7:4] == timer_pkg::ADDR_LOW0[7:4] & ~|rd_off[1:0];
	wire rd_hit = rd_cnt | rd_low |
		rd_off == timer_pkg::ADDR_CTRL |
		rd_off == timer_pkg::ADDR_PORT_DIR |
		rd_off == timer_pkg::ADDR_PORT_SFR |
		rd_off == timer_pkg::ADDR_STATUS |
		rd_off == timer_pkg::ADDR_EVEN_HIGH |
		rd_off == timer_pkg::ADDR_ODD_HIGH;
	wire [31:0] rd_val =
		rd_cnt ? {24'h0, cnt[rd_off[3:2]]} :
		rd_low ? {24'h0, low_reload[rd_off[3:2]]} :
		rd_off == timer_pkg::ADDR_CTRL ? {21'h0, ctrl} :
		rd_off == timer_pkg::ADDR_PORT_DIR ? {24'h0, port_b_direction} :
		rd_off == timer_pkg::ADDR_PORT_SFR ?
			{24'h0, port_b_special_function} :
		rd_off == timer_pkg::ADDR_STATUS ? rd_status :
		rd_off == timer_pkg::ADDR_EVEN_HIGH ? {24'h0, even_high_reload} :
		rd_off == timer_pkg::ADDR_ODD_HIGH ? {24'h0, odd_high_reload} :
		32'h0;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= timer_pkg::RESP_OKAY;
		end
		else if (arvalid & arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
		end
		else if (rvalid & rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule

/* test/cascade_timers_assertions.sv */
// Port-level checks for the cascadable down-timer unit
`timescale 1ns/1ps
module cascade_timers_checker
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// Timer outputs
	input wire logic [3:0] timer_irq,
	input wire logic toggle_pin_o
);
	// Mirrors the shared prescaler phase
	logic [2:0] phase;
	always_ff @(posedge clk)
	begin
		if (rst)
			phase <= 3'h0;
		else
			phase <= phase + 3'h1;
	end
	default clocking dck @(posedge clk);
	endclocking
	default disable iff (rst);
	a_irq_phase: assert property (|timer_irq |-> phase == 3'h0)
		else $error("interrupt off the tick phase");
	a_irq_pulse: assert property (|timer_irq |=> timer_irq == 4'h0)
		else $error("interrupt longer than one cycle");
	a_pin_phase: assert property (!$past(rst) && $changed(toggle_pin_o)
		|-> phase == 3'h0)
		else $error("toggle pin moved off the tick phase");
	a_pin_cause: assert property (!$past(rst) && $changed(toggle_pin_o)
		|-> timer_irq[0] || timer_irq[1])
		else $error("toggle pin moved without an expiry");
	a_pin_rise: assert property (!$past(rst) && $rose(toggle_pin_o)
		|-> timer_irq[0])
		else $error("toggle pin rose without even interrupt");
	a_reset_quiet: assert property (disable iff (1'b0) rst
		|=> timer_irq == 4'h0 && !toggle_pin_o && !bvalid && !rvalid)
		else $error("outputs active after reset");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		|=> ##1 bvalid)
		else $error("write answer late");
endmodule

bind cascade_timers cascade_timers_checker u_checker (.clk, .rst, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
	.rdata, .rvalid, .rready, .timer_irq, .toggle_pin_o);

/* test/cascade_timers_tb.sv */
// Self-checking bench for the cascadable down-timer unit
`timescale 1ns/1ps
module cascade_timers_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, toggle_pin_o, toggle_pin_oe;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, got;
	logic [3:0] timer_irq;
	logic pin_a;
	logic seen3 = 1'b0;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int t_a, t_b;
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) if (timer_irq[3] === 1'b1) seen3 = 1'b1;
	cascade_timers u_dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .timer_irq, .toggle_pin_o,
		.toggle_pin_oe);
	function automatic logic [7:0] cnt_a(input int i);
		return timer_pkg::ADDR_CNT0 + 8'(4 * i);
	endfunction
	function automatic logic [7:0] low_a(input int i);
		return timer_pkg::ADDR_LOW0 + 8'(4 * i);
	endfunction
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang;
		fails++;
		$display("wrong value wait expected done seen timeout");
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb, tv;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		repeat (40)
		begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			tv = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb === 1'b1)
			begin
				bready <= 1'b0;
				return;
			end
			if (tv === 1'b1)
				bready <= 1'b1;
		end
		hang();
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr, tv;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		repeat (40)
		begin
			@(negedge clk);
			ta = arvalid & arready;
			tr = rvalid & rready;
			tv = rvalid;
			got = rdata;
			resp = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			if (tr === 1'b1)
			begin
				rready <= 1'b0;
				return;
			end
			if (tv === 1'b1)
				rready <= 1'b1;
		end
		hang();
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, got);
	endtask
	// Waits for one timer interrupt, noting its cycle and the pin level
	task automatic wait_irq(input int b, input int lim);
		repeat (lim)
		begin
			@(negedge clk);
			if (timer_irq[b] === 1'b1)
			begin
				t_a = t_b;
				t_b = cyc;
				pin_a = toggle_pin_o;
				return;
			end
		end
		hang();
	endtask
	task automatic t_reset;
		rchk("ctrl", timer_pkg::ADDR_CTRL, 32'h0);
		rchk("count0", cnt_a(0), 32'h0);
		wr(8'h40, 32'h1);
		chk("bresp", timer_pkg::RESP_SLVERR, resp);
		rd(8'h40);
		chk("rresp", timer_pkg::RESP_SLVERR, resp);
		$display("test reset done");
	endtask
	task automatic t_single;
		wr(low_a(2), 32'h5);
		wr(cnt_a(2), 32'h80);
		wr(timer_pkg::ADDR_CTRL, 32'h4);
		wr(cnt_a(2), 32'h2);
		wait_irq(2, 40);
		rchk("count2", cnt_a(2), 32'h0);
		rchk("ctrl", timer_pkg::ADDR_CTRL, 32'h0);
		$display("test single done");
	endtask
	task automatic t_auto;
		logic p;
		wr(low_a(0), 32'h4);
		wr(cnt_a(0), 32'h2);
		wr(timer_pkg::ADDR_CTRL, 32'h11);
		wait_irq(0, 17);
		p = pin_a;
		wait_irq(0, 40);
		chk("period", 32'd32, 32'(t_b - t_a));
		chk("toggle", {31'h0, ~p}, {31'h0, pin_a});
		rd(cnt_a(0));
		rd(low_a(0));
		wr(low_a(0), 32'h2);
		wait_irq(0, 40);
		chk("period", 32'd32, 32'(t_b - t_a));
		wait_irq(0, 40);
		chk("period", 32'd16, 32'(t_b - t_a));
		wr(timer_pkg::ADDR_CTRL, 32'h0);
		$display("test auto done");
	endtask
	task automatic t_casc;
		wr(low_a(2), 32'h1);
		wr(low_a(3), 32'h1);
		wr(cnt_a(2), 32'h2);
		wr(cnt_a(3), 32'h0);
		wr(timer_pkg::ADDR_CTRL, 32'h204);
		wait_irq(2, 30);
		rchk("count3", cnt_a(3), 32'h1);
		wait_irq(2, 2100);
		chk("period", 32'd2056, 32'(t_b - t_a));
		chk("odd irq", 32'h0, {31'h0, seen3});
		wr(timer_pkg::ADDR_CTRL, 32'h0);
		$display("test cascade done");
	endtask
	task automatic t_pwm;
		wr(low_a(0), 32'h2);
		wr(low_a(1), 32'h0);
		wr(timer_pkg::ADDR_EVEN_HIGH, 32'h3);
		wr(timer_pkg::ADDR_ODD_HIGH, 32'h0);
		wr(cnt_a(0), 32'h1);
		wr(cnt_a(1), 32'h0);
		wr(timer_pkg::ADDR_CTRL, 32'h501);
		wait_irq(1, 20);
		wait_irq(0, 20);
		chk("low phase", 32'd16, 32'(t_b - t_a));
		chk("pin", 32'h1, {31'h0, pin_a});
		wait_irq(1, 30);
		chk("high phase", 32'd24, 32'(t_b - t_a));
		chk("pin", 32'h0, {31'h0, pin_a});
		wr(timer_pkg::ADDR_CTRL, 32'h0);
		$display("test pwm done");
	endtask
	task automatic t_port;
		wr(timer_pkg::ADDR_PORT_DIR, 32'h2);
		wr(timer_pkg::ADDR_PORT_SFR, 32'h2);
		chk("bresp", timer_pkg::RESP_OKAY, resp);
		chk("oe", 32'h1, {31'h0, toggle_pin_oe});
		wr(timer_pkg::ADDR_PORT_SFR, 32'h0);
		chk("oe", 32'h0, {31'h0, toggle_pin_oe});
		$display("test port done");
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_single();
		t_auto();
		t_casc();
		t_pwm();
		t_port();
		close_out();
	end
endmodule
